// >>> hdl/irq_arb_defs.vh
`ifndef IRQ_ARB_DEFS_VH
`define IRQ_ARB_DEFS_VH

// source count: natural order positions 0 to 53
`define NUM_SRC 54
`define LVL_W 3
`define IDX_W 6
`define VEC_W 8
// vector number = interrupt number + this
`define VEC_OFFSET 8'h08

// register word indices; byte address = index * 4
`define ADDR_W 8
`define IDX_FLAG0 6'h00
`define IDX_FLAG1 6'h01
`define IDX_EN0 6'h02
`define IDX_EN1 6'h03
`define IDX_PRIO0 6'h04
`define NUM_PRIO_REGS 14
`define IDX_PRIO_LAST 6'h11
`define IDX_VEC 6'h12
`define IDX_ISTAT 6'h13
`define IDX_IMASK 6'h14

// priority config: four 4-bit nibbles per 16-bit register
`define NIB_W 4
`define SRC_PER_PRIO 4

// vector readback fields
`define VEC_VALID_BIT 8
`define VEC_LVL_LSB 12

// interrupt status bits
`define ISTAT_W 2
`define IST_NEW_REQ 0
`define IST_WIN_CHG 1

// reset values
`define RST_FLAG 1'b0
`define RST_EN 1'b0
`define RST_PRIO 3'h0
`define RST_ISTAT 2'h0
`define RST_IMASK 2'h0

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hdl/prio_resolver.v
`timescale 1ns/1ns
`include "irq_arb_defs.vh"

module prio_resolver (
  // candidates
  input wire [`NUM_SRC-1:0] active,
  input wire [`NUM_SRC*`LVL_W-1:0] levels,
  // winner
  output wire win_valid,
  output wire [`IDX_W-1:0] win_idx,
  output wire [`LVL_W-1:0] win_lvl
);

  wire [`LVL_W-1:0] best_lvl [0:`NUM_SRC];
  wire [`IDX_W-1:0] best_idx [0:`NUM_SRC];

  assign best_lvl[0] = {`LVL_W{1'b0}};
  assign best_idx[0] = {`IDX_W{1'b0}};

  // scan from position 0 upward; a later source replaces only on a strictly
  // higher level, so ties stay with the lower interrupt number
  genvar i;
  generate
    for (i = 0; i < `NUM_SRC; i = i + 1) begin : g_scan
      // a genvar cannot be part-selected, so the position is held at index width
      localparam [`IDX_W-1:0] POS = i;
      wire [`LVL_W-1:0] lvl = levels[i*`LVL_W +: `LVL_W];
      wire take = active[i] && (lvl > best_lvl[i]);
      assign best_lvl[i+1] = take ? lvl : best_lvl[i];
      assign best_idx[i+1] = take ? POS : best_idx[i];
    end
  endgenerate

  // level 0 can never beat the initial 0, so it is never chosen
  assign win_valid = (best_lvl[`NUM_SRC] != {`LVL_W{1'b0}});
  assign win_idx = best_idx[`NUM_SRC];
  assign win_lvl = best_lvl[`NUM_SRC];

endmodule

// >>> hdl/interrupt_priority_arbiter.v
`timescale 1ns/1ns
`include "irq_arb_defs.vh"

module interrupt_priority_arbiter (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // request events from peripherals and external pins
  input wire [`NUM_SRC-1:0] src_event,
  // axi4-lite write address
  input wire [`ADDR_W-1:0] awaddr,
  input wire awvalid,
  output reg awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read address
  input wire [`ADDR_W-1:0] araddr,
  input wire arvalid,
  output reg arready,
  // axi4-lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // to the processor core
  output reg core_request,
  output reg [`VEC_W-1:0] core_vector,
  output reg [`LVL_W-1:0] core_level,
  // interrupt line
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture

  reg aw_held;
  reg w_held;
  reg [`ADDR_W-1:0] aw_addr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire wr_fire;
  wire [5:0] wr_idx;
  wire wr_mapped;

  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_idx = aw_addr_q[7:2];
  assign wr_mapped = (wr_idx <= `IDX_IMASK) && (wr_idx != `IDX_VEC);

  // address and data are taken in either order; both stall until the
  // response is accepted, so at most one write is in flight
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= {`ADDR_W{1'b0}};
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-source flags, enables and priorities

  reg [`NUM_SRC-1:0] flag;
  reg [`NUM_SRC-1:0] enable;
  reg [`NUM_SRC*`LVL_W-1:0] prio;
  wire [`NUM_SRC-1:0] pending;
  wire [`NUM_PRIO_REGS*16-1:0] prio_nib;

  genvar i;
  generate
    for (i = 0; i < `NUM_SRC; i = i + 1) begin : g_src
      localparam [5:0] FLAG_W = `IDX_FLAG0 + i / 32;
      localparam [5:0] EN_W = `IDX_EN0 + i / 32;
      localparam [5:0] PRIO_W = `IDX_PRIO0 + i / `SRC_PER_PRIO;
      localparam BIT = i % 32;
      localparam NIB = i % `SRC_PER_PRIO;
      wire clr;
      wire en_wr;
      wire prio_wr;

      assign clr = wr_fire && (wr_idx == FLAG_W) && wstrb_q[BIT/8] && wdata_q[BIT];
      assign en_wr = wr_fire && (wr_idx == EN_W) && wstrb_q[BIT/8];
      assign prio_wr = wr_fire && (wr_idx == PRIO_W) && wstrb_q[NIB/2];

      // a new event in the clearing cycle keeps the flag set
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          flag[i] <= `RST_FLAG;
        end else begin
          flag[i] <= (flag[i] && !clr) || src_event[i];
        end
      end

      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          enable[i] <= `RST_EN;
        end else if (en_wr) begin
          enable[i] <= wdata_q[BIT];
        end
      end

      // bit 3 of the nibble is dropped on write
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          prio[i*`LVL_W +: `LVL_W] <= `RST_PRIO;
        end else if (prio_wr) begin
          prio[i*`LVL_W +: `LVL_W] <= wdata_q[NIB*`NIB_W +: `LVL_W];
        end
      end

      assign prio_nib[i*`NIB_W +: `NIB_W] = {1'b0, prio[i*`LVL_W +: `LVL_W]};
      assign pending[i] = flag[i] && enable[i];
    end
  endgenerate

  // nibbles past the last source read as zero
  assign prio_nib[`NUM_PRIO_REGS*16-1:`NUM_SRC*`NIB_W] = {(`NUM_PRIO_REGS*16-`NUM_SRC*`NIB_W){1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  wire win_valid;
  wire [`IDX_W-1:0] win_idx;
  wire [`LVL_W-1:0] win_lvl;
  wire [`VEC_W-1:0] win_vector;

  prio_resolver u_resolver (
    .active(pending),
    .levels(prio),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  assign win_vector = {{(`VEC_W-`IDX_W){1'b0}}, win_idx} + `VEC_OFFSET;

  // the core sees a registered copy, refreshed every cycle; a request
  // withdrawn by software disappears one cycle after the flag clears
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      core_request <= 1'b0;
      core_vector <= {`VEC_W{1'b0}};
      core_level <= {`LVL_W{1'b0}};
    end else begin
      core_request <= win_valid;
      core_vector <= win_valid ? win_vector : {`VEC_W{1'b0}};
      core_level <= win_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  reg [`ISTAT_W-1:0] istat;
  reg [`ISTAT_W-1:0] imask;
  wire [`ISTAT_W-1:0] ievent;
  wire [`ISTAT_W-1:0] iclr;
  wire [`ISTAT_W-1:0] next_istat;

  assign ievent[`IST_NEW_REQ] = win_valid && !core_request;
  assign ievent[`IST_WIN_CHG] = win_valid && core_request && (win_vector != core_vector);
  assign iclr = (wr_fire && (wr_idx == `IDX_ISTAT) && wstrb_q[0]) ? wdata_q[`ISTAT_W-1:0] : {`ISTAT_W{1'b0}};
  assign next_istat = (istat & ~iclr) | ievent;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      istat <= `RST_ISTAT;
      imask <= `RST_IMASK;
      irq <= 1'b0;
    end else begin
      istat <= next_istat;
      if (wr_fire && (wr_idx == `IDX_IMASK) && wstrb_q[0]) begin
        imask <= wdata_q[`ISTAT_W-1:0];
      end
      irq <= |(istat & imask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  reg [31:0] next_rdata;
  reg next_rerr;
  wire [5:0] rd_idx;

  assign rd_idx = araddr[7:2];

  always @* begin
    next_rdata = 32'h0;
    next_rerr = 1'b0;
    case (rd_idx)
      `IDX_FLAG0: next_rdata = flag[31:0];
      `IDX_FLAG1: next_rdata = {{(64-`NUM_SRC){1'b0}}, flag[`NUM_SRC-1:32]};
      `IDX_EN0: next_rdata = enable[31:0];
      `IDX_EN1: next_rdata = {{(64-`NUM_SRC){1'b0}}, enable[`NUM_SRC-1:32]};
      `IDX_VEC: begin
        next_rdata[`VEC_W-1:0] = core_vector;
        next_rdata[`VEC_VALID_BIT] = core_request;
        next_rdata[`VEC_LVL_LSB +: `LVL_W] = core_level;
      end
      `IDX_ISTAT: next_rdata = {{(32-`ISTAT_W){1'b0}}, istat};
      `IDX_IMASK: next_rdata = {{(32-`ISTAT_W){1'b0}}, imask};
      default: begin
        if (rd_idx >= `IDX_PRIO0 && rd_idx <= `IDX_PRIO_LAST) begin
          next_rdata = {16'h0, prio_nib[(rd_idx - `IDX_PRIO0)*16 +: 16]};
        end else begin
          next_rerr = 1'b1;
        end
      end
    endcase
  end

  // one read in flight; arready drops until the data is taken
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

// >>> testbench/arb_props.sv
`timescale 1ns/1ns
`include "irq_arb_defs.vh"
module arb_props (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // register bus handshakes
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  // offer to the core
  input wire core_request,
  input wire [`VEC_W-1:0] core_vector,
  input wire [`LVL_W-1:0] core_level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_vec_range:
  assert property (core_request |-> core_vector >= 8'h08 && core_vector <= 8'h3D) else $error("vector out of range");
  a_idle_zero:
  assert property (!core_request |-> core_vector == 8'h00 && core_level == 3'h0) else $error("idle offer not zero");
  a_level_nonzero:
  assert property (core_request |-> core_level != 3'h0) else $error("level zero source offered");
  a_wr_answer:
  assert property (s_wr_taken |=> !bvalid ##1 bvalid) else $error("write response late");
  a_rd_answer:
  assert property (s_rd_taken |=> rvalid && !arready) else $error("read data late");
  a_rd_blocked:
  assert property (rvalid |-> !arready) else $error("read taken while data pending");
  a_wr_blocked:
  assert property (bvalid |-> !awready && !wready) else $error("write taken while response pending");
  a_rd_release:
  assert property (rvalid && rready |=> !rvalid ##1 arready) else $error("read channel not released");
  a_wr_release:
  assert property (bvalid && bready |=> !bvalid) else $error("write response not released");
endmodule

// >>> testbench/core_model.sv
`timescale 1ns/1ns
// stands in for the core: takes the offered vector at every edge
module core_model (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // offer from the arbiter
  input wire core_request,
  input wire [7:0] core_vector,
  input wire [2:0] core_level,
  // what the core last took
  output reg [11:0] taken
);
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      taken <= 12'h000;
    end else begin
      taken <= {core_request, core_level, core_vector};
    end
  end
endmodule

// >>> testbench/tb_interrupt_priority_arbiter.sv
`timescale 1ns/1ns
`include "irq_arb_defs.vh"
module tb_interrupt_priority_arbiter;
  reg clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready;
  reg [`NUM_SRC-1:0] src_event;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, rv;
  reg [3:0] wstrb;
  reg [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, core_request, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] core_vector;
  wire [2:0] core_level;
  wire [11:0] taken;
  integer err_total, tests_run, cyc;
  interrupt_priority_arbiter i_dut (.clk_sys, .rst_b, .src_event, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .core_request, .core_vector, .core_level, .irq);
  core_model i_core (.clk_sys, .rst_b, .core_request, .core_vector, .core_level, .taken);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // each channel is released at the edge it is taken on
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    rs = bresp;
  endtask
  task rd(input [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    rv = rdata;
    rs = rresp;
  endtask
  task set_prio(input integer n, input [2:0] l);
    wr(8'h10 + 8'(4 * (n / 4)), 32'(l) << (4 * (n % 4)));
  endtask
  task fire(input [`NUM_SRC-1:0] m);
    @(posedge clk_sys);
    src_event <= m;
    @(posedge clk_sys);
    src_event <= '0;
  endtask
  task core_chk(input [11:0] e);
    repeat (3) @(posedge clk_sys);
    chk({20'h0, taken}, {20'h0, e});
  endtask
  task clear_flags;
    wr(8'h00, 32'hFFFFFFFF);
    wr(8'h04, 32'h003FFFFF);
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      conclude;
    end
  end
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, src_event, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    err_total = 0;
    tests_run = 0;
    cyc = 0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'h1;
    rd(8'h10);
    chk(rv, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    chk(rs, 32'h0);
    rd(8'h10);
    chk(rv, 32'h00007777);
    chk(rs, 32'h0);
    rd(8'h54);
    chk(rv, 32'h0);
    chk(rs, 2'h2);
    wr(8'h48, 32'h0);
    chk(rs, 2'h2);
    wr(8'h10, 32'h0);
    $display("register test done");
    wr(8'h08, 32'h00000021);
    wr(8'h0C, 32'h00200400);
    set_prio(0, 3'h1);
    set_prio(42, 3'h7);
    fire(54'h1 | (54'h1 << 42));
    core_chk({1'h1, 3'h7, 8'h32});
    set_prio(42, 3'h0);
    core_chk({1'h1, 3'h1, 8'h08});
    clear_flags;
    core_chk(12'h000);
    $display("level test done");
    set_prio(5, 3'h4);
    set_prio(53, 3'h4);
    fire((54'h1 << 5) | (54'h1 << 53));
    core_chk({1'h1, 3'h4, 8'h0D});
    wr(8'h00, 32'h00000020);
    set_prio(0, 3'h3);
    fire(54'h1);
    core_chk({1'h1, 3'h4, 8'h3D});
    $display("tie test done");
    clear_flags;
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h0);
    fire(54'h1);
    core_chk(12'h000);
    wr(8'h14, 32'h1);
    wr(8'h50, 32'h1);
    wr(8'h4C, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wr(8'h08, 32'h1);
    core_chk({1'h1, 3'h3, 8'h08});
    chk({31'h0, irq}, 32'h1);
    rd(8'h48);
    chk(rv, 32'h00003108);
    rd(8'h4C);
    chk(rv & 32'h1, 32'h1);
    wr(8'h50, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wr(8'h50, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(8'h4C, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    // a higher source arriving while a request stands changes the winner
    wr(8'h50, 32'h2);
    wr(8'h38, 32'h00000700);
    wr(8'h0C, 32'h00000400);
    fire(54'h1 << 42);
    core_chk({1'h1, 3'h7, 8'h32});
    chk({31'h0, irq}, 32'h1);
    rd(8'h4C);
    chk(rv, 32'h2);
    rd(8'h48);
    chk(rv, 32'h00007132);
    $display("enable and interrupt test done");
    conclude;
  end
endmodule
bind interrupt_priority_arbiter arb_props i_props (.clk_sys, .rst_b, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .core_request, .core_vector, .core_level);
